/* hdl/pattern_pkg.sv */
// Purpose: Shared constants and types of the pulse pattern register block
// Assumes: One 100 MHz clock; AXI4-Lite register access
// Notes:   Printed offsets are word indices; byte address is index times 4
// Operation
// (RULE1) Low-port direction: 8 bits, write-only
// (RULE2) High-port direction: 8 bits, write-only
// (RULE3) Software sets direction for pattern pins
// (RULE4) Low-port data holds groups 0 and 1
// (RULE5) Enabled low-port data bits ignore CPU writes
// (RULE6) High-port data: groups 2, 3; resets zero
// (RULE7) Selected match copies staged low bits out
// (RULE8) Group 2/3 match copies staged high bits
// (RULE9) Staged registers clear on reset and standby
// (RULE10) Shared low trigger: whole byte, other ones
// (RULE11) Split low trigger: nibbles at two addresses
// (RULE12) Shared high trigger: whole byte, other ones
// (RULE13) Split high trigger: nibbles at two addresses
// (RULE14) Low enable bit gates each low transfer
// (RULE15) High enable bit gates each high transfer
// (RULE16) Enable registers clear on reset and standby
// (RULE17) Two-bit trigger select per group, resets ones
// (RULE18) Normal mode updates on compare match A
// (RULE19) Match pulse copies on its sampling edge
package pattern_pkg;

  localparam int ADDR_W = 18;
  localparam int IDX_W  = 16;

  // Register indices (byte address = index * 4)
  localparam logic [IDX_W-1:0] IDX_TRIG_SEL   = 16'hFFA1;
  localparam logic [IDX_W-1:0] IDX_HIGH_EN    = 16'hFFA2;
  localparam logic [IDX_W-1:0] IDX_LOW_EN     = 16'hFFA3;
  localparam logic [IDX_W-1:0] IDX_NDR_HIGH   = 16'hFFA4;
  localparam logic [IDX_W-1:0] IDX_NDR_LOW    = 16'hFFA5;
  localparam logic [IDX_W-1:0] IDX_NDR_G2_ALT = 16'hFFA6;
  localparam logic [IDX_W-1:0] IDX_NDR_G0_ALT = 16'hFFA7;
  localparam logic [IDX_W-1:0] IDX_LOW_DIR    = 16'hFFD1;
  localparam logic [IDX_W-1:0] IDX_LOW_DATA   = 16'hFFD3;
  localparam logic [IDX_W-1:0] IDX_HIGH_DIR   = 16'hFFD4;
  localparam logic [IDX_W-1:0] IDX_HIGH_DATA  = 16'hFFD6;

  // Reset values and ones used to fill reserved read bits
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] RST_TRIG_SEL = 8'hFF;
  localparam logic [7:0] RESERVED_ONES = 8'hFF;
  localparam logic [3:0] NIBBLE_ONES  = 4'hF;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Trigger select field width (two bits per group)
  localparam int SEL_W = 2;

  // State of the top module apart from the reset release pipe
  typedef struct packed {
    logic [7:0]       low_dir;
    logic [7:0]       high_dir;
    logic [7:0]       low_data;
    logic [7:0]       high_data;
    logic [7:0]       low_en;
    logic [7:0]       high_en;
    logic [7:0]       trig_sel;
    logic [7:0]       ndr_low;
    logic [7:0]       ndr_high;
    logic             aw_got;
    logic             w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0]       w_byte;
    logic             w_lane0;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [7:0]       rdata;
  } regs_t;

  // Per-group transfer inputs carried together
  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic [3:0]       enable;
    logic [3:0]       staged;
    logic [3:0]       current;
    logic             cpu_write;
    logic [3:0]       cpu_data;
  } group_in_t;

endpackage

/* hdl/pattern_group.sv */
// Purpose: Next value of one 4-bit pattern group of a port data register
// Assumes: Compare match A inputs are one-cycle pulses in the clk domain
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/100ps
module pattern_group
  import pattern_pkg::*;
(
  // Group controls and data
  input  wire group_in_t  gin,
  // Compare match A of timer channels 0 to 3
  input  wire logic [3:0] match_a,
  // Next port nibble
  output logic [3:0]      next_bits
);

  logic trigger;

  // Selected channel's compare match A fires the group
  assign trigger = match_a[gin.sel]; // RULE17 RULE18

  // Enabled bits follow the staged data on the trigger edge; enabled
  // bits are read-only, so a CPU write only reaches disabled bits
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      if (gin.enable[b]) begin
        next_bits[b] = trigger ? gin.staged[b] : gin.current[b]; // RULE14 RULE19
      end else if (gin.cpu_write) begin
        next_bits[b] = gin.cpu_data[b];
      end else begin
        next_bits[b] = gin.current[b]; // RULE5
      end
    end
  end

endmodule

/* hdl/pulse_pattern_next_data_regs.sv */
// Purpose: Staged pattern registers, port data/direction, AXI4-Lite slave
// Assumes: Timer compare match A pulses are synchronous to clk
// Notes:   Non-overlap waveform mode is not provided
`timescale 1ns/100ps
module pulse_pattern_next_data_regs
  import pattern_pkg::*;
(
  // Clock and reset
  input  wire  logic              clk,
  input  wire  logic              resetn,
  // Hardware standby request, clears the control and data registers like reset
  input  wire  logic              hw_standby,
  // Compare match A pulses of timer channels 0 to 3
  input  wire  logic [3:0]        compare_match_a,
  // AXI4-Lite write address
  input  wire  logic              s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire  logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire  logic [2:0]        s_axi_awprot,
  // AXI4-Lite write data
  input  wire  logic              s_axi_wvalid,
  output logic                    s_axi_wready,
  input  wire  logic [31:0]       s_axi_wdata,
  input  wire  logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                    s_axi_bvalid,
  input  wire  logic              s_axi_bready,
  output logic [1:0]              s_axi_bresp,
  // AXI4-Lite read address
  input  wire  logic              s_axi_arvalid,
  output logic                    s_axi_arready,
  input  wire  logic [ADDR_W-1:0] s_axi_araddr,
  input  wire  logic [2:0]        s_axi_arprot,
  // AXI4-Lite read data
  output logic                    s_axi_rvalid,
  input  wire  logic              s_axi_rready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  // Pattern output ports
  output logic [7:0]              low_port_bits,
  output logic [7:0]              low_port_oe,
  output logic [7:0]              high_port_bits,
  output logic [7:0]              high_port_oe
);

  regs_t       s;
  regs_t       next_s;
  logic        rst_n;
  logic [1:0]  rst_pipe;
  logic        clear;
  logic        low_same;
  logic        high_same;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_write;
  logic [IDX_W-1:0] w_idx;
  logic [IDX_W-1:0] r_idx;
  logic        w_ok;
  logic        r_ok;
  logic [7:0]  r_byte;
  logic [7:0]  wb;
  logic        wr_low_data;
  logic        wr_high_data;
  group_in_t   gin [4];
  logic [3:0]  gnext [4];
  logic [7:0]  low_xfer;
  logic [7:0]  high_xfer;

  // Reset release pipe; the rest of the design sees rst_n
  // Kept apart from the state struct: it runs on the raw reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Standby clears the same control and data registers as reset, not the bus state;
  // software standby is simply the absence of both, so nothing is lost there
  assign clear = hw_standby;

  // Paired groups share a trigger when their select fields match
  assign low_same  = s.trig_sel[1:0] == s.trig_sel[3:2];
  assign high_same = s.trig_sel[5:4] == s.trig_sel[7:6];

  // Handshakes: one write and one read outstanding at a time
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready  = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign aw_take  = s_axi_awvalid && s_axi_awready;
  assign w_take   = s_axi_wvalid && s_axi_wready;
  assign ar_take  = s_axi_arvalid && s_axi_arready;
  assign do_write = s.aw_got && s.w_got;

  // Register index of the held write and of the incoming read
  assign w_idx = s.aw_addr[ADDR_W-1:2];
  assign r_idx = s_axi_araddr[ADDR_W-1:2];
  assign wb    = s.w_byte;

  // Write address decode; misaligned addresses are unmapped
  always_comb begin
    w_ok = 1'b0;
    if (s.aw_addr[1:0] == 2'h0) begin
      unique case (w_idx)
        IDX_TRIG_SEL, IDX_HIGH_EN, IDX_LOW_EN, IDX_NDR_HIGH,
        IDX_NDR_LOW, IDX_NDR_G2_ALT, IDX_NDR_G0_ALT, IDX_LOW_DIR,
        IDX_LOW_DATA, IDX_HIGH_DIR, IDX_HIGH_DATA: w_ok = 1'b1;
        default: w_ok = 1'b0;
      endcase
    end
  end

  // Read mux; reserved next-data bits read as ones
  always_comb begin
    r_ok   = s_axi_araddr[1:0] == 2'h0;
    r_byte = RST_BYTE;
    unique case (r_idx)
      IDX_TRIG_SEL:  r_byte = s.trig_sel;
      IDX_HIGH_EN:   r_byte = s.high_en;
      IDX_LOW_EN:    r_byte = s.low_en;
      IDX_LOW_DIR:   r_byte = RST_BYTE; // RULE1
      IDX_HIGH_DIR:  r_byte = RST_BYTE; // RULE2
      IDX_LOW_DATA:  r_byte = s.low_data; // RULE4
      IDX_HIGH_DATA: r_byte = s.high_data; // RULE6
      IDX_NDR_LOW: begin
        if (low_same) begin
          r_byte = s.ndr_low; // RULE10
        end else begin
          r_byte = {s.ndr_low[7:4], NIBBLE_ONES}; // RULE11
        end
      end
      IDX_NDR_G0_ALT: begin
        if (low_same) begin
          r_byte = RESERVED_ONES; // RULE10
        end else begin
          r_byte = {NIBBLE_ONES, s.ndr_low[3:0]}; // RULE11
        end
      end
      IDX_NDR_HIGH: begin
        if (high_same) begin
          r_byte = s.ndr_high; // RULE12
        end else begin
          r_byte = {s.ndr_high[7:4], NIBBLE_ONES}; // RULE13
        end
      end
      IDX_NDR_G2_ALT: begin
        if (high_same) begin
          r_byte = RESERVED_ONES; // RULE12
        end else begin
          r_byte = {NIBBLE_ONES, s.ndr_high[3:0]}; // RULE13
        end
      end
      default: r_ok = 1'b0;
    endcase
  end

  // CPU writes into the port data registers, lane 0 only
  assign wr_low_data  = do_write && s.w_lane0 && w_ok &&
                        w_idx == IDX_LOW_DATA;
  assign wr_high_data = do_write && s.w_lane0 && w_ok &&
                        w_idx == IDX_HIGH_DATA;

  // Group controls: groups 0 and 1 on the low port, 2 and 3 on the high
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      gin[g].sel = s.trig_sel[g*SEL_W +: SEL_W]; // RULE17
      if (g < 2) begin
        gin[g].enable    = s.low_en[(g%2)*4 +: 4];
        gin[g].staged    = s.ndr_low[(g%2)*4 +: 4];
        gin[g].current   = s.low_data[(g%2)*4 +: 4];
        gin[g].cpu_write = wr_low_data;
      end else begin
        gin[g].enable    = s.high_en[(g%2)*4 +: 4];
        gin[g].staged    = s.ndr_high[(g%2)*4 +: 4];
        gin[g].current   = s.high_data[(g%2)*4 +: 4];
        gin[g].cpu_write = wr_high_data;
      end
      gin[g].cpu_data = wb[(g%2)*4 +: 4];
    end
  end

  // One transfer unit per group
  for (genvar g = 0; g < 4; g++) begin : grp
    pattern_group u_group (
      .gin       (gin[g]),
      .match_a   (compare_match_a),
      .next_bits (gnext[g])
    );
  end

  assign low_xfer  = {gnext[1], gnext[0]}; // RULE7
  assign high_xfer = {gnext[3], gnext[2]}; // RULE8

  // Next state of every register
  always_comb begin
    next_s          = s;

    // Port data follows the transfer units every cycle
    next_s.low_data  = low_xfer; // RULE5 RULE14
    next_s.high_data = high_xfer; // RULE6 RULE15

    // Write channel capture, either order
    if (aw_take) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_s.w_got   = 1'b1;
      next_s.w_byte  = s_axi_wdata[7:0];
      next_s.w_lane0 = s_axi_wstrb[0];
    end

    // Perform the write once both halves are held
    if (do_write) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = w_ok ? RESP_OKAY : RESP_SLVERR;
      // Misaligned or unmapped writes answer with an error, change nothing
      if (s.w_lane0 && w_ok) begin
        unique case (w_idx)
          IDX_TRIG_SEL: next_s.trig_sel = wb;
          IDX_HIGH_EN:  next_s.high_en  = wb;
          IDX_LOW_EN:   next_s.low_en   = wb;
          IDX_LOW_DIR:  next_s.low_dir  = wb; // RULE1 RULE3
          IDX_HIGH_DIR: next_s.high_dir = wb; // RULE2 RULE3
          IDX_NDR_LOW: begin
            if (low_same) begin
              next_s.ndr_low = wb; // RULE10
            end else begin
              next_s.ndr_low[7:4] = wb[7:4]; // RULE11
            end
          end
          IDX_NDR_G0_ALT: begin
            if (!low_same) begin
              next_s.ndr_low[3:0] = wb[3:0]; // RULE11
            end
          end
          IDX_NDR_HIGH: begin
            if (high_same) begin
              next_s.ndr_high = wb; // RULE12
            end else begin
              next_s.ndr_high[7:4] = wb[7:4]; // RULE13
            end
          end
          IDX_NDR_G2_ALT: begin
            if (!high_same) begin
              next_s.ndr_high[3:0] = wb[3:0]; // RULE13
            end
          end
          default: next_s.trig_sel = s.trig_sel;
        endcase
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Read: answer registered on the same edge that takes the address
    if (ar_take) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = r_ok ? r_byte : RST_BYTE;
      next_s.rresp  = r_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // Hardware standby clears registers but lets the bus finish
    if (clear) begin
      next_s.low_dir   = RST_BYTE;
      next_s.high_dir  = RST_BYTE;
      next_s.low_data  = RST_BYTE;
      next_s.high_data = RST_BYTE; // RULE6
      next_s.low_en    = RST_BYTE; // RULE16
      next_s.high_en   = RST_BYTE; // RULE16
      next_s.ndr_low   = RST_BYTE; // RULE9
      next_s.ndr_high  = RST_BYTE; // RULE9
      next_s.trig_sel  = RST_TRIG_SEL; // RULE17
    end
  end

  // State register, cleared by the released reset copy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s.low_dir   <= RST_BYTE;
      s.high_dir  <= RST_BYTE;
      s.low_data  <= RST_BYTE;
      s.high_data <= RST_BYTE; // RULE6
      s.low_en    <= RST_BYTE; // RULE16
      s.high_en   <= RST_BYTE; // RULE16
      s.trig_sel  <= RST_TRIG_SEL; // RULE17
      s.ndr_low   <= RST_BYTE; // RULE9
      s.ndr_high  <= RST_BYTE; // RULE9
      s.aw_got    <= 1'b0;
      s.w_got     <= 1'b0;
      s.aw_addr   <= '0;
      s.w_byte    <= RST_BYTE;
      s.w_lane0   <= 1'b0;
      s.bvalid    <= 1'b0;
      s.bresp     <= RESP_OKAY;
      s.rvalid    <= 1'b0;
      s.rresp     <= RESP_OKAY;
      s.rdata     <= RST_BYTE;
    end else begin
      s.low_dir   <= next_s.low_dir;
      s.high_dir  <= next_s.high_dir;
      s.low_data  <= next_s.low_data;
      s.high_data <= next_s.high_data;
      s.low_en    <= next_s.low_en;
      s.high_en   <= next_s.high_en;
      s.trig_sel  <= next_s.trig_sel;
      s.ndr_low   <= next_s.ndr_low;
      s.ndr_high  <= next_s.ndr_high;
      s.aw_got    <= next_s.aw_got;
      s.w_got     <= next_s.w_got;
      s.aw_addr   <= next_s.aw_addr;
      s.w_byte    <= next_s.w_byte;
      s.w_lane0   <= next_s.w_lane0;
      s.bvalid    <= next_s.bvalid;
      s.bresp     <= next_s.bresp;
      s.rvalid    <= next_s.rvalid;
      s.rresp     <= next_s.rresp;
      s.rdata     <= next_s.rdata;
    end
  end

  // Bus outputs straight from flip-flops; narrow data in the low byte
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp  = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp  = s.rresp;
  assign s_axi_rdata  = {24'h000000, s.rdata};

  // Pins: direction register drives the enable of each pin
  assign low_port_bits  = s.low_data;
  assign low_port_oe    = s.low_dir; // RULE3
  assign high_port_bits = s.high_data;
  assign high_port_oe   = s.high_dir; // RULE3

endmodule

/* sim/pattern_checker.sv */
// Purpose: Bus and port checks for the pattern register block
// Assumes: Bound to the top module; sees its ports only
// Notes:   All checks are off while resetn is low
`timescale 1ns/100ps
module pattern_checker
  import pattern_pkg::*;
(
  // Clock, reset and controls
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        hw_standby,
  input wire logic [3:0]  compare_match_a,
  // Bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pattern ports
  input wire logic [7:0]  low_port_bits,
  input wire logic [7:0]  low_port_oe,
  input wire logic [7:0]  high_port_bits,
  input wire logic [7:0]  high_port_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Answers stand until the master takes them
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write answer dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  // One transfer of each kind at a time
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  // Standby clears the ports on the next edge
  a_standby_clears: assert property (hw_standby |=> low_port_bits == 0 &&
    high_port_bits == 0 && low_port_oe == 0 && high_port_oe == 0)
    else $error("standby left a port set");
  // Port data moves only on a trigger, a write or standby
  a_low_cause: assert property ($changed(low_port_bits) |->
    $past(compare_match_a) != 0 || $rose(s_axi_bvalid) || $past(hw_standby))
    else $error("low port changed without cause");
  a_high_cause: assert property ($changed(high_port_bits) |->
    $past(compare_match_a) != 0 || $rose(s_axi_bvalid) || $past(hw_standby))
    else $error("high port changed without cause");
  a_dir_cause: assert property ($changed({low_port_oe, high_port_oe})
    |-> $rose(s_axi_bvalid) || $past(hw_standby))
    else $error("direction changed without a write");

  // Main scenarios reached
  c_write: cover property ($rose(s_axi_bvalid));
  c_trigger: cover property (compare_match_a != 0 ##1
    $changed(low_port_bits));
  c_standby: cover property (hw_standby);
endmodule

/* sim/pattern_load.sv */
// Purpose: Loads on the pattern pins, giving the level each pin carries
// Assumes: No pull resistor on these lines
// Notes:   Undriven pins toggle every cycle so no stale level passes
`timescale 1ns/100ps
module pattern_load (
  // Clock
  input  wire logic       clk,
  // Port data and direction from the block
  input  wire logic [7:0] low_bits,
  input  wire logic [7:0] low_oe,
  input  wire logic [7:0] high_bits,
  input  wire logic [7:0] high_oe,
  // Pin levels, high port above low
  output logic [15:0]     pins
);
  logic [15:0] drift = 16'h0000;

  // Floating pins wander, a driven pin shows its data bit
  always_ff @(posedge clk) drift <= ~drift;
  assign pins = ({high_oe, low_oe} & {high_bits, low_bits}) |
                (~{high_oe, low_oe} & drift);
endmodule

/* sim/pulse_pattern_next_data_regs_test.sv */
// Purpose: Directed bench for the pattern register block
// Assumes: Requests start on the fourth edge after reset release
// Notes:   Handshakes sampled mid-cycle, inputs move on rising edges
`timescale 1ns/100ps
module pulse_pattern_next_data_regs_test;
  import pattern_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, hw_standby = 1'b0;
  logic [3:0] compare_match_a = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] low_port_bits, low_port_oe, high_port_bits, high_port_oe;
  logic [15:0] pins;
  int miscompares = 0;
  int cmp_count = 0;

  always #5 clk = ~clk;

  pulse_pattern_next_data_regs i_dut (
    .clk(clk), .resetn(resetn), .hw_standby(hw_standby),
    .compare_match_a(compare_match_a),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .low_port_bits(low_port_bits),
    .low_port_oe(low_port_oe), .high_port_bits(high_port_bits),
    .high_port_oe(high_port_oe));

  pattern_load i_load (.clk(clk), .low_bits(low_port_bits),
    .low_oe(low_port_oe), .high_bits(high_port_bits),
    .high_oe(high_port_oe), .pins(pins));

  // Verdict and end of run
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // A bounded wait ran out: the block is hung
  task automatic hang();
    miscompares++;
    $display("MISMATCH t=%0t bus wait ran out", $time);
    finish_test();
  endtask

  // Sampling at the falling edge sees what the next rising edge takes
  task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic ta, tw, tb;
    logic [1:0] r;
    tb = 1'b0;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= {24'h0, d};
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 20 && !tb; n++) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    if (!tb) hang();
    else chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] ed,
                    input logic [1:0] er = RESP_OKAY);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    tr = 1'b0;
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 20 && !tr; n++) begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    if (!tr) begin
      hang();
    end else begin
      chk(d, {24'h0, ed});
      chk({30'h0, r}, {30'h0, er});
    end
  endtask

  // One-cycle match pulse; ports and pins judged after its edge
  task automatic pulse(input int ch, input logic [7:0] el, eh);
    @(posedge clk);
    compare_match_a <= 4'h1 << ch;
    @(posedge clk);
    compare_match_a <= 4'h0;
    @(negedge clk);
    chk({24'h0, low_port_bits}, {24'h0, el});
    chk({24'h0, high_port_bits}, {24'h0, eh});
    chk({16'h0, pins}, {16'h0, eh, el});
  endtask

  task automatic t_reset();
    rd(IDX_TRIG_SEL, RST_TRIG_SEL);
    rd(IDX_HIGH_EN, RST_BYTE);
    rd(IDX_LOW_EN, RST_BYTE);
    rd(IDX_NDR_LOW, RST_BYTE);
    rd(IDX_NDR_HIGH, RST_BYTE);
    rd(IDX_NDR_G0_ALT, RESERVED_ONES);
    rd(IDX_NDR_G2_ALT, RESERVED_ONES);
    rd(IDX_HIGH_DATA, RST_BYTE);
    rd(16'h0000, 8'h00, RESP_SLVERR);
    wr(16'h0000, 8'h11, RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic t_dir();
    wr(IDX_LOW_DIR, 8'hA5);
    wr(IDX_HIGH_DIR, 8'h3C);
    @(negedge clk);
    chk({24'h0, low_port_oe}, 32'hA5);
    chk({24'h0, high_port_oe}, 32'h3C);
    chk({16'h0, pins & 16'h3CA5}, 32'h0);
    rd(IDX_LOW_DIR, 8'h00);
    wr(IDX_LOW_DIR, 8'hFF);
    wr(IDX_HIGH_DIR, 8'hFF);
    $display("test direction done");
  endtask

  task automatic t_shared();
    wr(IDX_NDR_LOW, 8'hA5);
    wr(IDX_NDR_G0_ALT, 8'h00);
    rd(IDX_NDR_G0_ALT, RESERVED_ONES);
    wr(IDX_LOW_EN, 8'hFF);
    wr(IDX_NDR_HIGH, 8'h5A);
    wr(IDX_HIGH_EN, 8'hFF);
    pulse(0, 8'h00, 8'h00);
    pulse(3, 8'hA5, 8'h5A);
    wr(IDX_LOW_DATA, 8'h00);
    rd(IDX_LOW_DATA, 8'hA5);
    wr(IDX_LOW_EN, 8'h0F);
    wr(IDX_NDR_LOW, 8'h3C);
    pulse(3, 8'hAC, 8'h5A);
    wr(IDX_LOW_DATA, 8'hFF);
    rd(IDX_LOW_DATA, 8'hFC);
    $display("test shared trigger done");
  endtask

  task automatic t_split();
    wr(IDX_TRIG_SEL, 8'hE4);
    wr(IDX_LOW_EN, 8'hFF);
    wr(IDX_NDR_LOW, 8'h96);
    rd(IDX_NDR_LOW, 8'h9F);
    wr(IDX_NDR_G0_ALT, 8'h63);
    rd(IDX_NDR_G0_ALT, 8'hF3);
    pulse(1, 8'h9C, 8'h5A);
    pulse(0, 8'h93, 8'h5A);
    wr(IDX_NDR_HIGH, 8'h71);
    wr(IDX_NDR_G2_ALT, 8'hE5);
    rd(IDX_NDR_G2_ALT, 8'hF5);
    pulse(2, 8'h93, 8'h55);
    pulse(3, 8'h93, 8'h75);
    wr(IDX_HIGH_EN, 8'hF0);
    wr(IDX_NDR_G2_ALT, 8'h09);
    pulse(2, 8'h93, 8'h75);
    $display("test split trigger done");
  endtask

  task automatic t_standby();
    @(posedge clk);
    hw_standby <= 1'b1;
    @(posedge clk);
    hw_standby <= 1'b0;
    @(negedge clk);
    chk({low_port_bits, high_port_bits, low_port_oe, high_port_oe}, 0);
    rd(IDX_TRIG_SEL, RST_TRIG_SEL);
    rd(IDX_LOW_EN, RST_BYTE);
    rd(IDX_NDR_LOW, RST_BYTE);
    $display("test standby done");
  endtask

  // Main sequence: reset for five cycles, then each scenario
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_dir();
    t_shared();
    t_split();
    t_standby();
    finish_test();
  end
endmodule

bind pulse_pattern_next_data_regs pattern_checker i_chk (
  .clk(clk), .resetn(resetn), .hw_standby(hw_standby),
  .compare_match_a(compare_match_a), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .low_port_bits(low_port_bits), .low_port_oe(low_port_oe),
  .high_port_bits(high_port_bits), .high_port_oe(high_port_oe));
